// ---- hw/sfr_pkg.sv ----
// Purpose: constants and carriers for the core special-function registers
// Assumes: 8-bit data memory, special registers from address 0x00
// Notes: addresses follow the data memory map of the core
`default_nettype none
package sfr_pkg;
  localparam logic [7:0] addr_port_zero = 8'h00;
  localparam logic [7:0] addr_ptr_zero = 8'h01;
  localparam logic [7:0] addr_port_one = 8'h02;
  localparam logic [7:0] addr_ptr_one = 8'h03;
  localparam logic [7:0] addr_bank_sel = 8'h04;
  localparam logic [7:0] addr_working = 8'h05;
  localparam logic [7:0] addr_pc_low = 8'h06;
  localparam logic [7:0] addr_tbl_low = 8'h07;
  localparam logic [7:0] addr_tbl_result = 8'h08;
  localparam logic [7:0] addr_flags = 8'h0A;
  localparam logic [7:0] addr_irq_zero = 8'h0B;
  localparam logic [7:0] addr_tmr_high = 8'h0F;
  localparam logic [7:0] addr_tmr_low = 8'h10;
  localparam logic [7:0] addr_tmr_setup = 8'h11;
  localparam logic [7:0] addr_irq_one = 8'h1E;
  localparam logic [7:0] addr_tbl_high = 8'h1F;
  localparam logic [7:0] addr_gp_start = 8'h60;
  localparam logic [7:0] addr_gp_end = 8'hFF;
  localparam int gp_depth = 160;
  // flag bit positions
  localparam int flag_c = 0;
  localparam int flag_half = 1;
  localparam int flag_z = 2;
  localparam int flag_wrap = 3;
  localparam int flag_sleep = 4;
  localparam int flag_wdog = 5;
  localparam logic [7:0] flag_sw_mask = 8'hCF;
  // irq control zero bit positions
  localparam int irq_global = 0;
  localparam int irq_ext_en = 1;
  localparam int irq_tmr_en = 2;
  localparam int irq_usb_en = 3;
  // irq control one bit positions
  localparam int irq_spi_en = 0;
  // timer setup bit positions
  localparam int tmr_run = 4;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [7:0] one_byte = 8'h01;
  localparam logic [3:0] nib_one = 4'h1;

  typedef enum logic [3:0] {
    alu_pass, alu_add, alu_sub, alu_and, alu_or, alu_xor,
    alu_rlc, alu_rrc, alu_inc, alu_dec
  } alu_op_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic [7:0] result;
    logic c;
    logic half;
    logic z;
    logic wrap;
  } alu_out_s;
endpackage
`default_nettype wire

// ---- hw/sfr_alu.sv ----
// Purpose: 8-bit arithmetic and logic with flag generation
// Assumes: combinational, used by the special register block
// Notes: subtraction computes a minus b, carry means no borrow
`default_nettype none
module sfr_alu (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire sfr_pkg::alu_op_e op,
  // result
  output sfr_pkg::alu_out_s res
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] r;
  logic c;
  logic half;
  logic wrap;
  logic arith;

  always_comb begin
    sum = {1'b0, a};
    low_sum = {1'b0, a[3:0]};
    r = a;
    c = carry_in;
    half = 1'b0;
    wrap = 1'b0;
    arith = 1'b0;
    case (op)
      sfr_pkg::alu_add, sfr_pkg::alu_inc: begin
        arith = 1'b1;
        if (op == sfr_pkg::alu_inc) begin
          sum = {1'b0, a} + {1'b0, sfr_pkg::one_byte};
          low_sum = {1'b0, a[3:0]} + {1'b0, sfr_pkg::nib_one};
        end else begin
          sum = {1'b0, a} + {1'b0, b};
          low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        end
      end
      sfr_pkg::alu_sub, sfr_pkg::alu_dec: begin
        arith = 1'b1;
        if (op == sfr_pkg::alu_dec) begin
          sum = {1'b0, a} + {1'b0, ~sfr_pkg::one_byte} + 9'h001;
          low_sum = {1'b0, a[3:0]} + {1'b0, ~sfr_pkg::nib_one} + 5'h01;
        end else begin
          sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
          low_sum = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        end
      end
      sfr_pkg::alu_and: r = a & b;
      sfr_pkg::alu_or: r = a | b;
      sfr_pkg::alu_xor: r = a ^ b;
      sfr_pkg::alu_rlc: begin
        r = {a[6:0], carry_in};
        c = a[7];
      end
      sfr_pkg::alu_rrc: begin
        r = {carry_in, a[7:1]};
        c = a[0];
      end
      default: r = a;
    endcase
    if (arith) begin
      r = sum[7:0];
      c = sum[8];
      half = low_sum[4];
      // carry into bit 7 differs from carry out of it
      wrap = (r[7] ^ a[7] ^ (op == sfr_pkg::alu_sub ? ~b[7] :
           (op == sfr_pkg::alu_dec ? 1'b1 :
           (op == sfr_pkg::alu_inc ? 1'b0 : b[7])))) ^ sum[8];
    end
  end

  assign res.result = r;
  assign res.c = c;
  assign res.half = half;
  assign res.z = (r == sfr_pkg::zero_byte);
  assign res.wrap = wrap;
endmodule
`default_nettype wire

// ---- hw/sfr_timer.sv ----
// Purpose: 16-bit up counter with software preload
// Assumes: counts one per enabled tick when running
// Notes: overflow is a one-cycle pulse
`default_nettype none
module sfr_timer (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic load_low,
  input wire logic load_high,
  input wire logic [7:0] load_data,
  // state
  output logic [15:0] count,
  output logic overflow
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic ovf_reg;
  wire logic step = run && tick;

  assign count_next = load_low ? {count_reg[15:8], load_data} :
                      load_high ? {load_data, count_reg[7:0]} :
                      step ? count_reg + 16'h0001 : count_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 16'h0000;
      ovf_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg <= step && !load_low && !load_high && &count_reg;
    end
  end

  assign count = count_reg;
  assign overflow = ovf_reg;
endmodule
`default_nettype wire

// ---- hw/core_special_registers.sv ----
// Purpose: special-function register set of an 8-bit core
// Assumes: core sequencer drives one memory access and one alu op per cycle
// Notes: general memory lives here as an array; bank 1 via pointer one only
`default_nettype none
module core_special_registers (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // data memory access from the core
  input wire sfr_pkg::mem_req_s req,
  input wire logic to_working,
  input wire logic use_working_a,
  input wire logic alu_en,
  input wire sfr_pkg::alu_op_e alu_op,
  input wire logic [7:0] imm,
  input wire logic use_imm,
  // program counter and table
  input wire logic [11:0] pc,
  input wire logic table_rd,
  input wire logic [14:0] table_data,
  input wire logic [7:0] table_dest,
  // system events
  input wire logic sleep_instr,
  input wire logic watchdog_kick_instr,
  input wire logic watchdog_timeout,
  input wire logic irq_enter,
  input wire logic irq_return_instr,
  input wire logic irq_ext_req,
  input wire logic irq_spi_req,
  input wire logic irq_usb_req,
  input wire logic timer_tick,
  // results to the core
  output logic [7:0] rdata,
  output logic [7:0] working_register,
  output logic [7:0] cpu_flags,
  output logic pc_jump,
  output logic [7:0] program_counter_low,
  output logic dummy_cycle,
  output logic [15:0] table_ptr,
  output logic irq_pending,
  output logic timer_overflow
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] pointer_zero_reg;
  logic [7:0] pointer_one_reg;
  logic bank_reg;
  logic [7:0] working_reg;
  logic [7:0] table_ptr_low_reg;
  logic [7:0] table_ptr_high_reg;
  logic [7:0] table_high_result_reg;
  logic [7:0] flags_reg;
  logic [7:0] irq_ctrl_zero_reg;
  logic [7:0] irq_ctrl_one_reg;
  logic [7:0] timer_setup_reg;
  logic [7:0] rdata_reg;
  logic jump_reg;
  logic [7:0] pc_low_out_reg;
  logic dummy_reg;
  logic irq_reg;
  logic [7:0] gp_mem [0:sfr_pkg::gp_depth-1];
  // bank one, reached only through pointer one
  logic [7:0] gp_mem1 [0:sfr_pkg::gp_depth-1];

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == sfr_pkg::addr_port_zero) ||
              (a == sfr_pkg::addr_port_one);
  endfunction

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (a >= sfr_pkg::addr_gp_start);
  endfunction

  wire logic via_zero = req.addr == sfr_pkg::addr_port_zero;
  wire logic via_one = req.addr == sfr_pkg::addr_port_one;
  wire logic [7:0] eff_addr = via_zero ? pointer_zero_reg :
                              via_one ? pointer_one_reg : req.addr;
  // pointer zero is fixed to bank zero
  wire logic eff_bank = via_one ? bank_reg : 1'b0;
  // a pointer aimed at a port gives a null access
  wire logic eff_null = (via_zero || via_one) && is_port(eff_addr);
  wire logic wr = req.valid && req.write && !eff_null;
  wire logic [7:0] gp_idx8 = eff_addr - sfr_pkg::addr_gp_start;
  wire logic gp_hit = is_gp(eff_addr);

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [15:0] tmr_count;
  logic [7:0] sfr_rd;
  logic [7:0] mem_rd;

  assign sfr_rd =
    (eff_addr == sfr_pkg::addr_ptr_zero) ? pointer_zero_reg :
    (eff_addr == sfr_pkg::addr_ptr_one) ? pointer_one_reg :
    (eff_addr == sfr_pkg::addr_bank_sel) ? {7'h00, bank_reg} :
    (eff_addr == sfr_pkg::addr_working) ? working_reg :
    (eff_addr == sfr_pkg::addr_pc_low) ? pc[7:0] :
    (eff_addr == sfr_pkg::addr_tbl_low) ? table_ptr_low_reg :
    (eff_addr == sfr_pkg::addr_tbl_result) ? table_high_result_reg :
    (eff_addr == sfr_pkg::addr_flags) ? flags_reg :
    (eff_addr == sfr_pkg::addr_irq_zero) ? irq_ctrl_zero_reg :
    (eff_addr == sfr_pkg::addr_tmr_high) ? tmr_count[15:8] :
    (eff_addr == sfr_pkg::addr_tmr_low) ? tmr_count[7:0] :
    (eff_addr == sfr_pkg::addr_tmr_setup) ? timer_setup_reg :
    (eff_addr == sfr_pkg::addr_irq_one) ? irq_ctrl_one_reg :
    (eff_addr == sfr_pkg::addr_tbl_high) ? table_ptr_high_reg :
    sfr_pkg::zero_byte;

  assign mem_rd = eff_null ? sfr_pkg::zero_byte :
                  gp_hit ? (eff_bank ? gp_mem1[gp_idx8] : gp_mem[gp_idx8]) :
                  sfr_rd;

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  sfr_pkg::alu_out_s alu_res;
  // operand b from the immediate, else from memory
  wire logic [7:0] opnd_b = use_imm ? imm : mem_rd;
  wire logic [7:0] opnd_a = use_working_a ? working_reg : mem_rd;

  sfr_alu u_alu (
    .a(opnd_a),
    .b(opnd_b),
    .carry_in(flags_reg[sfr_pkg::flag_c]),
    .op(alu_op),
    .res(alu_res)
  );

  // memory write data: alu result when alu drives memory, else request data
  wire logic [7:0] store_data = (alu_en && !to_working) ?
                                alu_res.result : req.wdata;
  // an alu op into the working register blocks the memory store
  wire logic mem_store = wr && !(alu_en && to_working);
  wire logic store_sfr = mem_store && !gp_hit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction

  // ----------------------------------------------------------------
  // timer
  // ----------------------------------------------------------------
  logic timer_overflow_w;
  logic tmr_ovf_reg;
  // overflow pulse retimed before it reaches the irq logic
  sfr_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .run(timer_setup_reg[sfr_pkg::tmr_run]),
    .tick(timer_tick),
    .load_low(store_sfr && hit(eff_addr, sfr_pkg::addr_tmr_low)),
    .load_high(store_sfr && hit(eff_addr, sfr_pkg::addr_tmr_high)),
    .load_data(store_data),
    .count(tmr_count),
    .overflow(timer_overflow_w)
  );

  // ----------------------------------------------------------------
  // flags next value
  // ----------------------------------------------------------------
  logic [7:0] flags_next;
  logic arith_op;
  assign arith_op = (alu_op == sfr_pkg::alu_add) ||
                    (alu_op == sfr_pkg::alu_sub) ||
                    (alu_op == sfr_pkg::alu_inc) ||
                    (alu_op == sfr_pkg::alu_dec);

  always_comb begin
    flags_next = flags_reg;
    if (store_sfr && hit(eff_addr, sfr_pkg::addr_flags)) begin
      flags_next = (store_data & sfr_pkg::flag_sw_mask) |
                   (flags_reg & ~sfr_pkg::flag_sw_mask);
    end
    if (alu_en && alu_op != sfr_pkg::alu_pass) begin
      flags_next[sfr_pkg::flag_z] = alu_res.z;
      if (arith_op || alu_op == sfr_pkg::alu_rlc ||
          alu_op == sfr_pkg::alu_rrc) begin
        flags_next[sfr_pkg::flag_c] = alu_res.c;
      end
      if (arith_op) begin
        flags_next[sfr_pkg::flag_half] = alu_res.half;
        flags_next[sfr_pkg::flag_wrap] = alu_res.wrap;
      end
    end
    if (watchdog_kick_instr) begin
      flags_next[sfr_pkg::flag_sleep] = 1'b0;
      flags_next[sfr_pkg::flag_wdog] = 1'b0;
    end
    if (sleep_instr) begin
      flags_next[sfr_pkg::flag_sleep] = 1'b1;
      flags_next[sfr_pkg::flag_wdog] = 1'b0;
    end
    // timeout applied last, so it wins the watchdog flag
    if (watchdog_timeout) begin
      flags_next[sfr_pkg::flag_wdog] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt control
  // ----------------------------------------------------------------
  logic [7:0] irqc0_next;
  always_comb begin
    irqc0_next = irq_ctrl_zero_reg;
    if (store_sfr && hit(eff_addr, sfr_pkg::addr_irq_zero)) begin
      irqc0_next = store_data;
    end
    if (irq_enter) begin
      irqc0_next[sfr_pkg::irq_global] = 1'b0;
    end else if (irq_return_instr) begin
      irqc0_next[sfr_pkg::irq_global] = 1'b1;
    end
  end

  // interrupt entry saves nothing here; flags stay as they are
  wire logic irq_any =
    irq_ctrl_zero_reg[sfr_pkg::irq_global] && (
    (irq_ext_req && irq_ctrl_zero_reg[sfr_pkg::irq_ext_en]) ||
    (tmr_ovf_reg && irq_ctrl_zero_reg[sfr_pkg::irq_tmr_en]) ||
    (irq_usb_req && irq_ctrl_zero_reg[sfr_pkg::irq_usb_en]) ||
    (irq_spi_req && irq_ctrl_one_reg[sfr_pkg::irq_spi_en]));

  // ----------------------------------------------------------------
  // register updates
  // ----------------------------------------------------------------
  // pc low write: jump pulse plus one dummy cycle
  wire logic pc_low_write = store_sfr && hit(eff_addr, sfr_pkg::addr_pc_low);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pointer_zero_reg <= sfr_pkg::zero_byte;
      pointer_one_reg <= sfr_pkg::zero_byte;
      bank_reg <= 1'b0;
      working_reg <= sfr_pkg::zero_byte;
      table_ptr_low_reg <= sfr_pkg::zero_byte;
      table_ptr_high_reg <= sfr_pkg::zero_byte;
      table_high_result_reg <= sfr_pkg::zero_byte;
      flags_reg <= sfr_pkg::zero_byte;
      irq_ctrl_zero_reg <= sfr_pkg::zero_byte;
      irq_ctrl_one_reg <= sfr_pkg::zero_byte;
      timer_setup_reg <= sfr_pkg::zero_byte;
    end else begin
      flags_reg <= flags_next;
      irq_ctrl_zero_reg <= irqc0_next;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_ptr_zero))
        pointer_zero_reg <= store_data;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_ptr_one))
        pointer_one_reg <= store_data;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_bank_sel))
        bank_reg <= store_data[0];
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_tbl_low))
        table_ptr_low_reg <= store_data;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_tbl_high))
        table_ptr_high_reg <= store_data;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_irq_one))
        irq_ctrl_one_reg <= store_data;
      if (store_sfr && hit(eff_addr, sfr_pkg::addr_tmr_setup))
        timer_setup_reg <= store_data;
      if (table_rd)
        table_high_result_reg <= {1'b0, table_data[14:8]};
      else if (store_sfr && hit(eff_addr, sfr_pkg::addr_tbl_result))
        table_high_result_reg <= store_data;
      if (alu_en && to_working)
        working_reg <= alu_res.result;
      else if (store_sfr && hit(eff_addr, sfr_pkg::addr_working))
        working_reg <= store_data;
    end
  end

  // general memory: table low byte to user location, else normal store
  wire logic [7:0] tdest_idx = table_dest - sfr_pkg::addr_gp_start;
  always_ff @(posedge clock) begin
    if (table_rd && is_gp(table_dest))
      gp_mem[tdest_idx] <= table_data[7:0];
    else if (mem_store && gp_hit && !eff_bank)
      gp_mem[gp_idx8] <= store_data;
    if (mem_store && gp_hit && eff_bank)
      gp_mem1[gp_idx8] <= store_data;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= sfr_pkg::zero_byte;
      jump_reg <= 1'b0;
      pc_low_out_reg <= sfr_pkg::zero_byte;
      dummy_reg <= 1'b0;
      irq_reg <= 1'b0;
      tmr_ovf_reg <= 1'b0;
    end else begin
      // read data stands one cycle after the request
      rdata_reg <= mem_rd;
      jump_reg <= pc_low_write;
      if (pc_low_write)
        pc_low_out_reg <= store_data;
      dummy_reg <= pc_low_write;
      irq_reg <= irq_any;
      tmr_ovf_reg <= timer_overflow_w;
    end
  end

  assign rdata = rdata_reg;
  assign working_register = working_reg;
  assign cpu_flags = flags_reg;
  assign pc_jump = jump_reg;
  assign program_counter_low = pc_low_out_reg;
  assign dummy_cycle = dummy_reg;
  assign table_ptr = {table_ptr_high_reg, table_ptr_low_reg};
  assign irq_pending = irq_reg;
  assign timer_overflow = tmr_ovf_reg;
endmodule
`default_nettype wire

// ---- dv/core_special_registers_asserts.sv ----
// Purpose: port checks for the special register block
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of the block
`default_nettype none
module core_special_registers_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // requests and events
  input wire sfr_pkg::mem_req_s req,
  input wire logic to_working,
  input wire logic alu_en,
  input wire sfr_pkg::alu_op_e alu_op,
  input wire logic [11:0] pc,
  input wire logic sleep_instr,
  input wire logic watchdog_kick_instr,
  input wire logic watchdog_timeout,
  input wire logic irq_enter,
  input wire logic irq_return_instr,
  // results
  input wire logic [7:0] rdata,
  input wire logic [7:0] working_register,
  input wire logic [7:0] cpu_flags,
  input wire logic pc_jump,
  input wire logic [7:0] program_counter_low,
  input wire logic dummy_cycle,
  input wire logic irq_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic rd = req.valid && !req.write;
  wire logic wr = req.valid && req.write;
  wire logic wr_pc = wr && req.addr == sfr_pkg::addr_pc_low;
  wire logic wr_fl = wr && req.addr == sfr_pkg::addr_flags;
  wire logic quiet = !sleep_instr && !watchdog_kick_instr && !watchdog_timeout;
  wire logic gap = req.addr == 8'h09 || req.addr inside {[8'h20:8'h5F]};
  a_pc_jump_load: assert property (wr_pc |=> pc_jump &&
    program_counter_low == $past(req.wdata)) else $error("no jump on pc write");
  a_jump_cause: assert property (pc_jump |-> $past(wr_pc))
    else $error("jump without pc write");
  a_dummy_pair: assert property (dummy_cycle == pc_jump)
    else $error("dummy cycle not paired with jump");
  a_pc_read: assert property (rd && req.addr == sfr_pkg::addr_pc_low
    |=> rdata == $past(pc[7:0])) else $error("pc low read wrong");
  a_gap_zero: assert property (rd && gap |=> rdata == 8'h00)
    else $error("unused address not zero");
  a_flag_guard: assert property (wr_fl && quiet
    |=> $stable(cpu_flags[5:4])) else $error("flag write hit system flags");
  a_sleep_flags: assert property (sleep_instr &&
    !watchdog_kick_instr && !watchdog_timeout |=> cpu_flags[5:4] == 2'b01)
    else $error("sleep flags");
  a_kick_clear: assert property (watchdog_kick_instr &&
    !sleep_instr && !watchdog_timeout |=> cpu_flags[5:4] == 2'b00)
    else $error("kick flags");
  a_timeout_set: assert property (watchdog_timeout |=> cpu_flags[5])
    else $error("timeout flag not set");
  a_enter_mask: assert property (irq_enter ##1 !irq_return_instr
    |=> !irq_pending) else $error("pending after irq entry");
  a_zero_flag: assert property (alu_en && to_working &&
    alu_op != sfr_pkg::alu_pass |=>
    cpu_flags[2] == (working_register == 8'h00))
    else $error("zero flag wrong");
  c_jump: cover property (wr_pc);
  c_timeout: cover property (watchdog_timeout);
  c_enter: cover property (irq_enter ##1 !irq_return_instr);
endmodule
bind core_special_registers core_special_registers_asserts chk_i (
  .clock(clock), .arst_n(arst_n), .req(req), .to_working(to_working),
  .alu_en(alu_en), .alu_op(alu_op), .pc(pc), .sleep_instr(sleep_instr),
  .watchdog_kick_instr(watchdog_kick_instr),
  .watchdog_timeout(watchdog_timeout), .irq_enter(irq_enter),
  .irq_return_instr(irq_return_instr), .rdata(rdata),
  .working_register(working_register), .cpu_flags(cpu_flags),
  .pc_jump(pc_jump), .program_counter_low(program_counter_low),
  .dummy_cycle(dummy_cycle), .irq_pending(irq_pending));
`default_nettype wire

// ---- dv/core_special_registers_tb.sv ----
// Purpose: directed bench for the special register block
// Assumes: one access per task call, rdata one cycle later
// Notes: events on ev_v: sleep, kick, timeout, enter, return
`default_nettype none
module core_special_registers_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  sfr_pkg::mem_req_s req = '0;
  logic to_working = 1'b0;
  logic use_working_a = 1'b0;
  logic alu_en = 1'b0;
  sfr_pkg::alu_op_e alu_op = sfr_pkg::alu_pass;
  logic [7:0] imm = 8'h00;
  logic use_imm = 1'b0;
  logic table_rd = 1'b0;
  logic [4:0] ev_v = 5'h00;
  logic [2:0] irq_req = 3'h0;
  logic timer_tick = 1'b0;
  logic ovf = 1'b0;
  logic [7:0] rdata, working_register, cpu_flags, program_counter_low;
  logic pc_jump, dummy_cycle, irq_pending, timer_overflow;
  logic [15:0] table_ptr;
  logic [7:0] unused [4] = '{8'h09, 8'h0C, 8'h20, 8'h5F};
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  core_special_registers core_special_registers_i (
    .clock(clock), .arst_n(arst_n), .req(req), .to_working(to_working),
    .use_working_a(use_working_a), .alu_en(alu_en), .alu_op(alu_op),
    .imm(imm), .use_imm(use_imm), .pc(12'h3A5), .table_rd(table_rd),
    .table_data(15'h5ABC), .table_dest(8'h63), .sleep_instr(ev_v[4]),
    .watchdog_kick_instr(ev_v[3]), .watchdog_timeout(ev_v[2]),
    .irq_enter(ev_v[1]), .irq_return_instr(ev_v[0]),
    .irq_ext_req(irq_req[0]), .irq_spi_req(irq_req[1]),
    .irq_usb_req(irq_req[2]), .timer_tick(timer_tick), .rdata(rdata),
    .working_register(working_register), .cpu_flags(cpu_flags),
    .pc_jump(pc_jump), .program_counter_low(program_counter_low),
    .dummy_cycle(dummy_cycle), .table_ptr(table_ptr),
    .irq_pending(irq_pending), .timer_overflow(timer_overflow));
  // ---------------------------------------------
  // access tasks
  // ---------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask
  task automatic ev(input logic [4:0] v);
    @(posedge clock);
    ev_v <= v;
    @(posedge clock);
    ev_v <= 5'h00;
    #1;
  endtask
  task automatic alu(input sfr_pkg::alu_op_e op, input logic [7:0] b);
    @(posedge clock);
    {alu_en, to_working, use_working_a, use_imm} <= 4'hF;
    alu_op <= op;
    imm <= b;
    @(posedge clock);
    alu_en <= 1'b0;
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rd(sfr_pkg::addr_flags, 8'h00);
    rd(sfr_pkg::addr_pc_low, 8'hA5);
    foreach (unused[i]) rd(unused[i], 8'h00);
    xfer(1'b1, 8'h61, 8'h11);
    xfer(1'b1, sfr_pkg::addr_ptr_zero, 8'h61);
    rd(sfr_pkg::addr_ptr_zero, 8'h61);
    rd(sfr_pkg::addr_port_zero, 8'h11);
    xfer(1'b1, sfr_pkg::addr_port_zero, 8'h22);
    rd(8'h61, 8'h22);
    xfer(1'b1, sfr_pkg::addr_bank_sel, 8'h01);
    xfer(1'b1, sfr_pkg::addr_ptr_one, 8'h61);
    xfer(1'b1, sfr_pkg::addr_port_one, 8'h77);
    rd(sfr_pkg::addr_port_one, 8'h77);
    rd(sfr_pkg::addr_port_zero, 8'h22);
    xfer(1'b1, sfr_pkg::addr_bank_sel, 8'h00);
    xfer(1'b1, sfr_pkg::addr_ptr_one, 8'h02);
    xfer(1'b1, sfr_pkg::addr_port_one, 8'hAA);
    rd(sfr_pkg::addr_port_one, 8'h00);
    rd(sfr_pkg::addr_ptr_one, 8'h02);
    $display("test indirect done");
    xfer(1'b1, sfr_pkg::addr_working, 8'h7F);
    alu(sfr_pkg::alu_add, 8'h01);
    chk(working_register, 8'h80);
    chk(cpu_flags, 8'h0A);
    alu(sfr_pkg::alu_sub, 8'h80);
    chk(cpu_flags, 8'h07);
    rd(sfr_pkg::addr_working, 8'h00);
    alu(sfr_pkg::alu_rlc, 8'h00);
    chk(working_register, 8'h01);
    chk(cpu_flags, 8'h02);
    alu(sfr_pkg::alu_rrc, 8'h00);
    chk(cpu_flags, 8'h07);
    alu(sfr_pkg::alu_xor, 8'hFF);
    chk(cpu_flags, 8'h03);
    xfer(1'b1, sfr_pkg::addr_flags, 8'hFF);
    rd(sfr_pkg::addr_flags, 8'hCF);
    ev(5'h10);
    chk(cpu_flags, 8'hDF);
    ev(5'h04);
    chk(cpu_flags, 8'hFF);
    xfer(1'b1, sfr_pkg::addr_flags, 8'h00);
    chk(cpu_flags, 8'h30);
    ev(5'h10);
    chk(cpu_flags, 8'h10);
    ev(5'h08);
    chk(cpu_flags, 8'h00);
    $display("test flags done");
    xfer(1'b1, sfr_pkg::addr_pc_low, 8'h40);
    chk({pc_jump, dummy_cycle, program_counter_low}, 10'h340);
    @(posedge clock);
    #1;
    chk({pc_jump, dummy_cycle}, 2'b00);
    xfer(1'b1, sfr_pkg::addr_tbl_low, 8'h34);
    xfer(1'b1, sfr_pkg::addr_tbl_high, 8'h12);
    chk(table_ptr, 16'h1234);
    @(posedge clock);
    table_rd <= 1'b1;
    @(posedge clock);
    table_rd <= 1'b0;
    rd(sfr_pkg::addr_tbl_result, 8'h5A);
    rd(8'h63, 8'hBC);
    $display("test pc and table done");
    xfer(1'b1, sfr_pkg::addr_irq_zero, 8'h03);
    @(posedge clock);
    irq_req <= 3'h6;
    repeat (3) @(posedge clock);
    #1;
    chk(irq_pending, 1'b0);
    @(posedge clock);
    irq_req <= 3'h7;
    repeat (3) @(posedge clock);
    #1;
    chk(irq_pending, 1'b1);
    ev(5'h02);
    @(posedge clock);
    #1;
    chk(irq_pending, 1'b0);
    chk(cpu_flags, 8'h00);
    ev(5'h01);
    @(posedge clock);
    #1;
    chk(irq_pending, 1'b1);
    xfer(1'b1, sfr_pkg::addr_tmr_low, 8'hFE);
    xfer(1'b1, sfr_pkg::addr_tmr_high, 8'hFF);
    rd(sfr_pkg::addr_tmr_low, 8'hFE);
    xfer(1'b1, sfr_pkg::addr_tmr_setup, 8'h10);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      timer_tick <= (i < 2);
      #1;
      ovf = ovf | timer_overflow;
    end
    chk(ovf, 1'b1);
    rd(sfr_pkg::addr_tmr_low, 8'h00);
    $display("test irq and timer done");
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end
endmodule
`default_nettype wire
